// ---- hw/dcd_pkg.sv ----
// Shared constants and types for the two-channel transfer engine
package dcd_pkg;
   // Register byte offsets inside one channel's window
   localparam logic [4:0] OFS_SRC_LO = 5'h00;
   localparam logic [4:0] OFS_SRC_HI = 5'h04;
   localparam logic [4:0] OFS_DST_LO = 5'h08;
   localparam logic [4:0] OFS_DST_HI = 5'h0C;
   localparam logic [4:0] OFS_COUNT = 5'h10;
   localparam logic [4:0] OFS_CTRL = 5'h14;
   // Channel windows and the shared status word
   localparam logic [7:0] CH0_BASE = 8'h00;
   localparam logic [7:0] CH1_BASE = 8'h20;
   localparam logic [7:0] STATUS_ADDR = 8'h40;
   // Control field positions
   localparam int CF_SYNC = 0;
   localparam int CF_WORD = 2;
   localparam int CF_INT = 3;
   localparam int CF_TC = 4;
   localparam int CF_PRIO = 5;
   localparam int CF_SSTEP = 6;
   localparam int CF_SIO = 8;
   localparam int CF_DSTEP = 9;
   localparam int CF_DIO = 11;
   localparam int CF_REQSRC = 12;
   localparam int CF_ARM = 14;
   // Synchronization, step and request source encodings
   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] SYNC_SRC = 2'h1;
   localparam logic [1:0] SYNC_DST = 2'h2;
   localparam logic [1:0] STEP_HOLD = 2'h0;
   localparam logic [1:0] STEP_INC = 2'h1;
   localparam logic [1:0] STEP_DEC = 2'h2;
   localparam logic [1:0] REQ_PIN = 2'h0;
   localparam logic [1:0] REQ_TIMER2 = 2'h1;
   localparam logic [1:0] REQ_SERIAL = 2'h2;
   localparam logic [1:0] REQ_SOFT = 2'h3;
   // Reset values
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [19:0] ADDR_RESET = 20'h0_0000;
   // Cycle figures: a transfer is two bus cycles of at least 4 clocks;
   // a destination-paced transfer spans 12 clocks when the CPU wants the
   // bus and 10 when it does not
   localparam int XFER_MIN_CLKS = 8;
   localparam int BUS_MIN_CLKS = XFER_MIN_CLKS / 2;
   localparam int DSYNC_CPU_CLKS = 12;
   localparam int DSYNC_IDLE_CLKS = 10;
   localparam logic [3:0] GAP_CPU = 4'(DSYNC_CPU_CLKS - XFER_MIN_CLKS);
   localparam logic [3:0] GAP_IDLE = 4'(DSYNC_IDLE_CLKS - XFER_MIN_CLKS);
   localparam logic [2:0] BUS_LAST = 3'(BUS_MIN_CLKS - 1);
   // One system bus cycle request
   typedef struct packed {
      logic [19:0] addr;
      logic io;
      logic write;
      logic word;
      logic [15:0] wdata;
   } dcd_bus_req_t;
   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_DEPOSIT, ST_GAP}
      dcd_state_t;
endpackage : dcd_pkg

// ---- hw/dcd_engine.sv ----
// Two-channel transfer engine with serial pacing and an AHB-Lite slave
// What this block does
// RL1 - Sustain 9, 10 or 12 clocks per transfer
// RL2 - Serial-assigned channel ignores its request pin
// RL3 - Software paces serial transmit by destination sync
// RL4 - Software paces serial receive by source sync
// RL5 - Control selects sync mode and byte/word
// RL6 - Optional end interrupt and terminal-count stop
// RL7 - Per-address step and memory/IO space select
// RL8 - Fixed priority or alternating between channels
// RL9 - Engine beats CPU except locked/odd-word pairs
// RL10 - Bus hold wins over pending transfers
// RL11 - NMI halts all transfer activity
// RL12 - Address, count, control registers, live writes
// RL13 - Count allows 64K transfers, auto termination
// RL14 - One selected request source per channel
// RL15 - Fetch then deposit, eight clocks minimum
// RL16 - Round-robin pointer set to the other channel on each grant
// RL17 - Interrupt held until acknowledged, set at end
`timescale 1ns/100ps
`default_nettype none
module dcd_engine
   import dcd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic bus_valid,
   output dcd_bus_req_t bus_req,
   input wire logic bus_done,
   input wire logic [15:0] bus_rdata,
   input wire logic cpu_bus_need,
   input wire logic cpu_locked,
   input wire logic cpu_odd_word,
   input wire logic hold_request,
   output logic hold_grant,
   input wire logic nmi_request,
   input wire logic [1:0] channel_request_pins,
   input wire logic timer2_request,
   input wire logic serial_tx_empty,
   input wire logic serial_rx_full,
   output logic [1:0] dma_irq
);
   ////////////////////////////////////////////////////////////////////////
   // State
   logic [19:0] src_reg [2]; // Source addresses
   logic [19:0] dst_reg [2]; // Destination addresses
   logic [15:0] transfer_count_reg [2]; // Remaining transfers
   logic [15:0] ctrl_reg [2]; // Channel modes
   logic [1:0] irq_reg; // Sticky end-of-count requests
   logic rr_reg; // Alternating pointer
   dcd_state_t state_reg;
   logic cur_ch_reg; // Channel being served
   logic [2:0] cyc_reg; // Clocks spent in this bus cycle
   logic done_seen_reg; // Bus cycle already acknowledged
   logic [3:0] gap_reg; // Pacing gap left
   dcd_bus_req_t bus_req_reg;
   logic wr_pend_reg; // AHB write waiting for its data phase
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;

   ////////////////////////////////////////////////////////////////////////
   // Step helper: hold, up or down by one byte or one word
   function automatic logic [19:0] step_addr(input logic [19:0] a,
      input logic [1:0] mode, input logic word);
      logic [19:0] d;
      d = word ? 20'h0_0002 : 20'h0_0001;
      case (mode)
         STEP_INC: step_addr = a + d;
         STEP_DEC: step_addr = a - d;
         default: step_addr = a;
      endcase
   endfunction : step_addr

   ////////////////////////////////////////////////////////////////////////
   // Request generation per channel
   wire logic [1:0] req;
   for (genvar i = 0; i < 2; i++) begin : g_req
      wire logic [1:0] sync = ctrl_reg[i][CF_SYNC +: 2];
      wire logic [1:0] rsrc = ctrl_reg[i][CF_REQSRC +: 2];
      // Serial pacing follows direction: transmitter empties, receiver fills
      wire logic ser_lvl = (sync == SYNC_DST) ? serial_tx_empty
                                              : serial_rx_full; // RL3 RL4
      // Pin only counts when selected, so a serial channel ignores it
      wire logic pin_lvl = (rsrc == REQ_PIN) && channel_request_pins[i]; // RL2
      wire logic lvl = pin_lvl || (rsrc == REQ_TIMER2 && timer2_request) ||
         (rsrc == REQ_SERIAL && ser_lvl) || (rsrc == REQ_SOFT); // RL14
      // Unsynchronized channels run free while armed
      assign req[i] = ctrl_reg[i][CF_ARM] &&
         ((sync == SYNC_NONE) || lvl); // RL5
   end

   ////////////////////////////////////////////////////////////////////////
   // Arbitration between channels and against CPU and hold
   wire logic prio0 = ctrl_reg[0][CF_PRIO];
   wire logic prio1 = ctrl_reg[1][CF_PRIO];
   wire logic both = &req;
   // Equal priority alternates; unequal picks the high one
   wire logic gnt_ch = !both ? req[1] :
      (prio0 != prio1) ? prio1 : rr_reg; // RL8 RL16
   // Locked or odd-word CPU pairs are never split by a new transfer
   wire logic cpu_block = cpu_locked || cpu_odd_word; // RL9
   wire logic idle = (state_reg == ST_IDLE);
   wire logic start = idle && (|req) && !hold_request && !nmi_request &&
      !cpu_block; // RL10 RL11
   assign hold_grant = hold_request && idle; // RL10

   ////////////////////////////////////////////////////////////////////////
   // Bus cycle completion: acknowledged and minimum length reached
   wire logic acked = done_seen_reg || bus_done;
   wire logic cyc_ok = acked && (cyc_reg >= BUS_LAST); // RL15
   wire logic [15:0] cur_ctrl = ctrl_reg[cur_ch_reg];
   wire logic cur_word = cur_ctrl[CF_WORD];
   // Byte mode: take the addressed lane, offer it on both lanes
   wire logic [7:0] fbyte = bus_req_reg.addr[0] ? bus_rdata[15:8]
                                                : bus_rdata[7:0];
   wire logic [15:0] fdata = cur_word ? bus_rdata : {fbyte, fbyte}; // RL5
   wire logic fin = (state_reg == ST_DEPOSIT) && cyc_ok;
   wire logic [15:0] cnt_dec = transfer_count_reg[cur_ch_reg] - 16'h0001;
   // Zero start wraps, giving the full 64K transfers
   wire logic tc_hit = fin && cur_ctrl[CF_TC] && (cnt_dec == 16'h0000); // RL13
   wire logic dsync = cur_ctrl[CF_SYNC +: 2] == SYNC_DST;
   wire logic [3:0] gap_len = cpu_bus_need ? GAP_CPU : GAP_IDLE; // RL1

   assign bus_valid = (state_reg == ST_FETCH || state_reg == ST_DEPOSIT) &&
      !done_seen_reg;
   assign bus_req = bus_req_reg;

   ////////////////////////////////////////////////////////////////////////
   // Transfer sequencer: fetch, deposit, optional pacing gap
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_reg <= ST_IDLE;
         cur_ch_reg <= 1'b0;
         rr_reg <= 1'b0;
         cyc_reg <= 3'h0;
         done_seen_reg <= 1'b0;
         gap_reg <= 4'h0;
         bus_req_reg <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start) begin
                  state_reg <= ST_FETCH; // RL15
                  cur_ch_reg <= gnt_ch;
                  rr_reg <= !gnt_ch; // RL16
                  cyc_reg <= 3'h0;
                  done_seen_reg <= 1'b0;
                  bus_req_reg <= '{src_reg[gnt_ch],
                     ctrl_reg[gnt_ch][CF_SIO], 1'b0,
                     ctrl_reg[gnt_ch][CF_WORD], 16'h0000}; // RL7
               end
            end
            ST_FETCH: begin
               cyc_reg <= (cyc_reg == BUS_LAST) ? cyc_reg : cyc_reg + 3'h1;
               done_seen_reg <= acked && !cyc_ok;
               // Deposit follows unconditionally so the pair is never split
               if (cyc_ok) begin
                  state_reg <= ST_DEPOSIT; // RL15
                  cyc_reg <= 3'h0;
                  bus_req_reg <= '{dst_reg[cur_ch_reg], cur_ctrl[CF_DIO],
                     1'b1, cur_word, fdata}; // RL7
               end
            end
            ST_DEPOSIT: begin
               cyc_reg <= (cyc_reg == BUS_LAST) ? cyc_reg : cyc_reg + 3'h1;
               done_seen_reg <= acked && !cyc_ok;
               if (cyc_ok) begin
                  // Destination pacing: gap plus the idle start cycle add 4 or 2
                  state_reg <= dsync ? ST_GAP : ST_IDLE; // RL1
                  gap_reg <= gap_len;
                  bus_req_reg.write <= 1'b0;
               end
            end
            ST_GAP: begin
               gap_reg <= gap_reg - 4'h1;
               if (gap_reg <= 4'h2) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave: zero wait states, always OKAY
   wire logic ahb_go = hsel && htrans[1] && hready;
   wire logic [7:0] a8 = haddr[7:0];
   wire logic rd_ch = a8[5];
   wire logic [4:0] rd_ofs = a8[4:0];
   wire logic rd_in_ch = (a8[7:6] == 2'b00) && (rd_ofs <= OFS_CTRL);
   wire logic [31:0] status_word = {26'h0, ctrl_reg[1][CF_ARM],
      ctrl_reg[0][CF_ARM], cur_ch_reg, !idle, irq_reg};
   logic [31:0] rd_val;
   always_comb begin
      rd_val = 32'h0000_0000;
      if (a8 == STATUS_ADDR) begin
         rd_val = status_word;
      end else if (rd_in_ch) begin
         case (rd_ofs)
            OFS_SRC_LO: rd_val = {16'h0, src_reg[rd_ch][15:0]};
            OFS_SRC_HI: rd_val = {28'h0, src_reg[rd_ch][19:16]};
            OFS_DST_LO: rd_val = {16'h0, dst_reg[rd_ch][15:0]};
            OFS_DST_HI: rd_val = {28'h0, dst_reg[rd_ch][19:16]};
            OFS_COUNT: rd_val = {16'h0, transfer_count_reg[rd_ch]};
            OFS_CTRL: rd_val = {16'h0, ctrl_reg[rd_ch]};
            default: rd_val = 32'h0000_0000;
         endcase
      end
   end
   assign hrdata = hrdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Address phase capture and read data staging
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= ahb_go && hwrite;
         wr_addr_reg <= a8;
         if (ahb_go && !hwrite) begin
            hrdata_reg <= rd_val;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel registers: software writes take effect at once and win, except that NMI disarm beats them
   wire logic w_ch = wr_addr_reg[5];
   wire logic [4:0] w_ofs = wr_addr_reg[4:0];
   wire logic w_in_ch = wr_pend_reg && (wr_addr_reg[7:6] == 2'b00);
   wire logic w_stat = wr_pend_reg && (wr_addr_reg == STATUS_ADDR);
   wire logic [1:0] irq_clr = w_stat ? hwdata[1:0] : 2'b00;
   assign dma_irq = irq_reg;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 2; i++) begin
            src_reg[i] <= ADDR_RESET;
            dst_reg[i] <= ADDR_RESET;
            transfer_count_reg[i] <= COUNT_RESET;
            ctrl_reg[i] <= CTRL_RESET;
         end
         irq_reg <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            // Hardware advance after each finished transfer
            if (fin && cur_ch_reg == 1'(i)) begin
               src_reg[i] <= step_addr(src_reg[i],
                  ctrl_reg[i][CF_SSTEP +: 2], ctrl_reg[i][CF_WORD]); // RL7
               dst_reg[i] <= step_addr(dst_reg[i],
                  ctrl_reg[i][CF_DSTEP +: 2], ctrl_reg[i][CF_WORD]); // RL7
               transfer_count_reg[i] <= cnt_dec;
               if (tc_hit) begin
                  ctrl_reg[i][CF_ARM] <= 1'b0; // RL6
               end
            end
            if (w_in_ch && w_ch == 1'(i)) begin
               case (w_ofs)
                  OFS_SRC_LO: src_reg[i][15:0] <= hwdata[15:0]; // RL12
                  OFS_SRC_HI: src_reg[i][19:16] <= hwdata[3:0];
                  OFS_DST_LO: dst_reg[i][15:0] <= hwdata[15:0];
                  OFS_DST_HI: dst_reg[i][19:16] <= hwdata[3:0];
                  OFS_COUNT: transfer_count_reg[i] <= hwdata[15:0];
                  OFS_CTRL: ctrl_reg[i] <= hwdata[15:0];
                  default: ;
               endcase
            end
            // NMI disarms both channels; software re-arms after service
            if (nmi_request) begin
               ctrl_reg[i][CF_ARM] <= 1'b0; // RL11
            end
         end
         // Set on the final transfer wins over a same-cycle clear
         irq_reg <= (irq_reg & ~irq_clr) |
            ({1'b0, tc_hit && cur_ctrl[CF_INT]} << cur_ch_reg); // RL6 RL17
      end
   end
endmodule : dcd_engine
`default_nettype wire

// ---- dv/dcd_engine_asserts.sv ----
// Port-level checks for the two-channel transfer engine
`timescale 1ns/100ps
`default_nettype none
module dcd_engine_asserts
   import dcd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic bus_valid,
   input wire dcd_bus_req_t bus_req,
   input wire logic bus_done,
   input wire logic cpu_locked,
   input wire logic cpu_odd_word,
   input wire logic hold_request,
   input wire logic hold_grant,
   input wire logic nmi_request,
   input wire logic [1:0] dma_irq
);
   ////////////////////////////////////////////////////////////////////////
   logic wr_q; // Status write taken last cycle, lands at this edge
   logic bv_q; // Bus request level one cycle ago
   wire fst; // A fresh fetch begins in this cycle
   assign fst = bus_valid && !bv_q && !bus_req.write;
   // Helper flops kept apart from the properties for clarity
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_q <= 1'b0;
         bv_q <= 1'b0;
      end else begin
         wr_q <= hsel && htrans[1] && hready && hwrite
            && haddr[7:0] == STATUS_ADDR;
         bv_q <= bus_valid;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_grant; hold_grant |-> hold_request && !bus_valid; endproperty
   a_grant: assert property (p_grant) else $error("grant while busy");
   property p_hold; $past(hold_request) |-> !fst; endproperty
   a_hold: assert property (p_hold) else $error("start under hold");
   property p_nmi; $past(nmi_request) |-> !fst; endproperty
   a_nmi: assert property (p_nmi) else $error("start under nmi");
   property p_lock; $past(cpu_locked) || $past(cpu_odd_word) |-> !fst;
   endproperty
   a_lock: assert property (p_lock) else $error("split cpu pair");
   property p_min4; fst |-> bus_valid [*4]; endproperty
   a_min4: assert property (p_min4) else $error("short cycle");
   property p_stand;
      bus_valid && !bus_done |=> bus_valid && $stable(bus_req);
   endproperty
   a_stand: assert property (p_stand) else $error("request moved");
   property p_depo;
      bus_valid && bus_done && !bus_req.write |=> ##[0:1]
         bus_valid && bus_req.write;
   endproperty
   a_depo: assert property (p_depo) else $error("no deposit");
   property p_irq_set;
      $rose(dma_irq[0]) |-> $past(bus_done && bus_valid && bus_req.write);
   endproperty
   a_irq_set: assert property (p_irq_set) else $error("early irq");
   property p_irq_keep; $fell(dma_irq[0]) |-> $past(wr_q); endproperty
   a_irq_keep: assert property (p_irq_keep) else $error("irq lost");
   c_irq: cover property ($rose(dma_irq[0]));
   c_grant: cover property (hold_grant);
   c_lock: cover property (cpu_odd_word && bus_valid);
endmodule : dcd_engine_asserts
`default_nettype wire

// ---- dv/dcd_mem_model.sv ----
// Behavioural memory and I/O standing on the engine's system bus
`timescale 1ns/100ps
`default_nettype none
module dcd_mem_model
   import dcd_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic bus_valid,
   input wire dcd_bus_req_t bus_req,
   input wire logic [3:0] wait_clks,
   output logic bus_done,
   output logic [15:0] bus_rdata,
   output logic [15:0] dep_count,
   output dcd_bus_req_t dep_req,
   output logic [19:0] dep_prev
);
   logic [3:0] cnt; // Clocks spent in the current bus cycle
   // Done no earlier than wait_clks; larger values model a slow device
   assign bus_done = bus_valid && cnt >= wait_clks;
   // Data follows the address; while waiting it changes every clock, idle it holds FFFF
   assign bus_rdata = bus_done
      ? {bus_req.addr[7:0] + 8'h40, bus_req.addr[7:0]} : {4{~cnt}};
   // Count clocks and log every deposit for the bench
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt <= 4'h0;
         dep_count <= 16'h0000;
         dep_req <= '0;
         dep_prev <= 20'h0_0000;
      end else begin
         cnt <= (bus_valid && !bus_done) ? cnt + 4'h1 : 4'h0;
         if (bus_done && bus_req.write) begin
            dep_count <= dep_count + 16'h0001;
            dep_req <= bus_req;
            dep_prev <= dep_req.addr;
         end
      end
   end
endmodule : dcd_mem_model
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the two-channel transfer engine
`timescale 1ns/100ps
`default_nettype none
module testbench
   import dcd_pkg::*;
;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
   logic [2:0] r = 3'b000; // Pin, timer 2 and receive requests of ch1
   logic [3:0] blk = 4'h0; // Hold, lock, odd word, nmi
   logic [3:0] wt = 4'h3; // Partner answer delay
   logic tx = 1'b0, need = 1'b0; // Transmit empty, CPU wants the bus
   logic [31:0] hrdata, q;
   logic hreadyout, hresp, bus_valid, bus_done, hold_grant;
   dcd_bus_req_t bus_req, dep_req;
   logic [15:0] bus_rdata, dep_count, c;
   logic [1:0] dma_irq;
   logic [19:0] dep_prev;
   int errors = 0;
   int n_tests = 0;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   dcd_engine u_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .bus_valid, .bus_req, .bus_done, .bus_rdata,
      .cpu_bus_need(need), .cpu_locked(blk[1]), .cpu_odd_word(blk[2]),
      .hold_request(blk[0]), .hold_grant, .nmi_request(blk[3]),
      .channel_request_pins({r[0], 1'b0}), .timer2_request(r[1]),
      .serial_tx_empty(tx), .serial_rx_full(r[2]), .dma_irq);
   dcd_mem_model u_mem (.clk, .reset, .bus_valid, .bus_req,
      .wait_clks(wt), .bus_done, .bus_rdata, .dep_count, .dep_req,
      .dep_prev);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask : chk
   // One single AHB transfer; q holds read data afterwards
   task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : ahb
   // Control word with the channel armed
   function automatic logic [15:0] cw(input logic [1:0] sy,
      input logic [1:0] rs, input logic [15:0] x);
      return x | 16'(sy) << CF_SYNC | 16'(rs) << CF_REQSRC | 16'h1 << CF_ARM;
   endfunction : cw
   task automatic prog(input logic [7:0] b, input logic [19:0] s,
      input logic [19:0] d, input logic [15:0] n, input logic [15:0] x);
      ahb(1'b1, b + 8'(OFS_SRC_LO), {16'h0000, s[15:0]});
      ahb(1'b1, b + 8'(OFS_SRC_HI), {28'h000_0000, s[19:16]});
      ahb(1'b1, b + 8'(OFS_DST_LO), {16'h0000, d[15:0]});
      ahb(1'b1, b + 8'(OFS_DST_HI), {28'h000_0000, d[19:16]});
      ahb(1'b1, b + 8'(OFS_COUNT), {16'h0000, n});
      ahb(1'b1, b + 8'(OFS_CTRL), {16'h0000, x});
   endtask : prog
   // Wait, bounded, for n more deposits
   task automatic waitd(input int n);
      logic [15:0] c0;
      c0 = dep_count;
      for (int k = 0; k < 400 && dep_count - c0 < n; k++) @(posedge clk);
   endtask : waitd
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      ahb(1'b0, CH0_BASE + 8'(OFS_CTRL), 32'h0);
      chk("ctrl reset", {16'h0000, CTRL_RESET}, q);
      chk("hresp okay", 32'h0, 32'(hresp));
      ahb(1'b1, CH1_BASE + 8'(OFS_SRC_HI), 32'hFFFF_FFFF);
      ahb(1'b0, CH1_BASE + 8'(OFS_SRC_HI), 32'h0);
      chk("src high", 32'h0000_000F, q);
      ahb(1'b1, CH1_BASE + 8'(OFS_COUNT), 32'h0001_FFFF);
      ahb(1'b0, CH1_BASE + 8'(OFS_COUNT), 32'h0);
      chk("count max", 32'h0000_FFFF, q);
      ahb(1'b1, 8'h7C, 32'hFFFF_FFFF);
      ahb(1'b0, 8'h7C, 32'h0);
      chk("unmapped", 32'h0000_0000, q);
   endtask : t_regs
   // Byte copy, src up, dst down into I/O, two counted transfers
   task automatic t_mem();
      c = dep_count;
      prog(CH0_BASE, 20'h0_0100, 20'h0_0200, 16'h0002, cw(SYNC_NONE,
         REQ_SOFT, 16'h1 << CF_INT | 16'h1 << CF_TC | 16'(STEP_INC) <<
         CF_SSTEP | 16'(STEP_DEC) << CF_DSTEP | 16'h1 << CF_DIO));
      for (int k = 0; k < 300 && dma_irq[0] !== 1'b1; k++) @(posedge clk);
      chk("irq set", 32'h1, 32'(dma_irq[0]));
      chk("dst step", 32'h0_01FF, 32'(dep_req.addr));
      chk("dst io", 32'h1, 32'(dep_req.io));
      chk("byte lanes", 32'h4141, 32'(dep_req.wdata));
      repeat (30) @(posedge clk);
      chk("tc stop", 32'(c + 16'h2), 32'(dep_count));
      ahb(1'b0, CH0_BASE + 8'(OFS_COUNT), 32'h0);
      chk("count end", 32'h0, q);
      ahb(1'b1, STATUS_ADDR, 32'h0000_0001);
      @(posedge clk);
      chk("irq cleared", 32'h0, 32'(dma_irq[0]));
   endtask : t_mem
   // Channel 1 follows only its selected request line
   task automatic t_src();
      logic [1:0] rs [3] = '{REQ_PIN, REQ_TIMER2, REQ_SERIAL};
      for (int i = 0; i < 3; i++) begin
         r <= ~(3'b001 << i);
         prog(CH1_BASE, 20'h0_0500, 20'h0_0600, 16'h0001,
            cw(SYNC_SRC, rs[i], 16'h1 << CF_TC));
         c = dep_count;
         repeat (20) @(posedge clk);
         chk("foreign request", 32'(c), 32'(dep_count));
         r <= 3'b001 << i;
         waitd(1);
         r <= 3'b000;
         chk("own request", 32'(c + 16'h1), 32'(dep_count));
      end
   endtask : t_src
   task automatic t_prio();
      prog(CH0_BASE, 20'h0_0100, 20'h0_0300, 16'h0000,
         cw(SYNC_NONE, REQ_SOFT, 16'h0));
      prog(CH1_BASE, 20'h0_0100, 20'h0_0400, 16'h0000,
         cw(SYNC_NONE, REQ_SOFT, 16'h1 << CF_WORD));
      waitd(3);
      chk("alternate", 32'h1, 32'(dep_req.addr[10] ^ dep_prev[10]));
      ahb(1'b1, CH1_BASE + 8'(OFS_CTRL),
         32'(cw(SYNC_NONE, REQ_SOFT, 16'h1 << CF_PRIO | 16'h1 << CF_WORD)));
      waitd(3);
      chk("fixed", 32'h3, {dep_req.addr[10], dep_prev[10]});
      chk("word data", 32'h4000, 32'(dep_req.wdata));
      chk("word flag", 32'h1, 32'(dep_req.word));
   endtask : t_prio
   // Transmit pacing: constant byte destination, destination sync,
   // spacing of 12 clocks with the CPU wanting the bus, else 10
   task automatic t_tx();
      int t0;
      wt <= 4'h3;
      r <= 3'b100;
      for (int i = 0; i < 2; i++) begin
         need <= (i == 0);
         tx <= 1'b0;
         prog(CH0_BASE, 20'h0_0010, 20'h0_00F0, 16'h0003,
            cw(SYNC_DST, REQ_SERIAL, 16'h1 << CF_TC));
         c = dep_count;
         repeat (20) @(posedge clk);
         chk("tx paced", 32'(c), 32'(dep_count));
         tx <= 1'b1;
         waitd(1);
         t0 = 0;
         c = dep_count;
         while (dep_count == c && t0 < 50) begin
            @(posedge clk);
            t0++;
         end
         chk("tx spacing", (i == 0) ? 32'hC : 32'hA, 32'(t0));
         chk("tx dst", 32'h0_00F0, 32'(dep_req.addr));
      end
      tx <= 1'b0;
      r <= 3'b000;
   endtask : t_tx
   // Hold, lock, odd word, then nmi each stop new transfers
   task automatic t_block();
      wt <= 4'h7;
      for (int i = 0; i < 4; i++) begin
         blk <= 4'h1 << i;
         repeat (25) @(posedge clk);
         c = dep_count;
         if (i == 0) chk("grant", 32'h1, 32'(hold_grant));
         repeat (30) @(posedge clk);
         chk("blocked", 32'(c), 32'(dep_count));
         blk <= 4'h0;
         waitd(1);
         chk("resume", 32'(i < 3), 32'(dep_count != c));
      end
      ahb(1'b0, STATUS_ADDR, 32'h0);
      chk("disarmed", 32'h0, 32'(q[5:4]));
   endtask : t_block
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_regs();
      t_mem();
      t_src();
      t_prio();
      t_block();
      t_tx();
      final_report();
   end
   // Watchdog well beyond the thousand or so cycles the tests need
   initial begin
      repeat (30000) @(posedge clk);
      errors++;
      final_report();
   end
endmodule : testbench
bind dcd_engine dcd_engine_asserts u_chk (.clk, .reset, .hsel, .haddr,
   .htrans, .hwrite, .hready, .bus_valid, .bus_req, .bus_done, .cpu_locked,
   .cpu_odd_word, .hold_request, .hold_grant, .nmi_request, .dma_irq);
`default_nettype wire
